//--- rtl/timer_pkg.sv
// Package for the 8/16-bit timer/counter: register offsets, fields, modes.
// Assumes a 32-bit APB master; each register is one aligned word.
package timer_pkg;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CNT_LOW  = 8'h04;
    localparam logic [7:0] OFF_CNT_HIGH = 8'h08;
    localparam logic [7:0] OFF_CMP_A    = 8'h0C;
    localparam logic [7:0] OFF_CMP_B    = 8'h10;
    localparam logic [7:0] OFF_FLAGS    = 8'h14;
    localparam logic [7:0] OFF_CAPTURE  = 8'h18;

    localparam int CTRL_WIDTH_BIT   = 7;
    localparam int CTRL_CAPTURE_BIT = 6;
    localparam int CTRL_CLEAR_BIT   = 3;
    localparam int CTRL_CS_LSB      = 0;
    localparam int CS_WIDTH         = 3;

    localparam int FLAG_OVF_BIT  = 0;
    localparam int FLAG_CMPA_BIT = 1;
    localparam int FLAG_CMPB_BIT = 2;
    localparam int FLAG_CAP_BIT  = 3;

    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [7:0]  BYTE_MAX  = 8'hFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE  = 16'h0001;
    localparam logic [15:0] WORD_MAX  = 16'hFFFF;
    localparam logic [31:0] BUS_ZERO  = 32'h0000_0000;
    localparam logic [2:0]  CS_STOP   = 3'h0;

    typedef enum logic [2:0] {
        MODE_NORMAL8  = 3'b000,
        MODE_CLEAR8   = 3'b001,
        MODE_NORMAL16 = 3'b011,
        MODE_CAPT8    = 3'b010,
        MODE_CAPT16   = 3'b110
    } timer_mode_e;

    typedef struct packed {
        logic       width_select;
        logic       capture_mode_enable;
        logic       clear_on_match_select;
        logic [2:0] clock_select_field;
    } timer_ctrl_s;

    typedef struct packed {
        logic overflow_flag;
        logic compare_flag_a;
        logic compare_flag_b;
        logic capture_flag;
    } timer_flags_s;
endpackage : timer_pkg

//--- rtl/timer_mode_decode.sv
// Decodes the three control bits into one of the five counting modes.
// Assumes a registered control word as input.
`timescale 1ns/1ps
module timer_mode_decode (
    input  wire timer_pkg::timer_ctrl_s ctrl,
    output timer_pkg::timer_mode_e      mode
);
    always_comb begin
        // Clear-on-match only counts when neither width nor capture is set
        if (ctrl.capture_mode_enable) begin
            mode = ctrl.width_select ? timer_pkg::MODE_CAPT16 : timer_pkg::MODE_CAPT8;
        end else if (ctrl.width_select) begin
            mode = timer_pkg::MODE_NORMAL16;
        end else if (ctrl.clear_on_match_select) begin
            mode = timer_pkg::MODE_CLEAR8;
        end else begin
            mode = timer_pkg::MODE_NORMAL8;
        end
    end
endmodule : timer_mode_decode

//--- rtl/timer_flag_bit.sv
// One sticky flag: hardware set beats software clear in the same cycle.
// Assumes synchronous active-low reset.
`timescale 1ns/1ps
module timer_flag_bit (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic set_evt,
    input  wire logic clr_evt,
    output logic      flag
);
    logic flag_reg;
    logic flag_next;

    always_comb begin
        flag_next = flag_reg;
        if (clr_evt) begin
            flag_next = 1'b0;
        end
        if (set_evt) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule : timer_flag_bit

//--- rtl/timer_modes_wide_access.sv
// 8/16-bit timer/counter with five modes and a shared high-byte latch.
// Assumes an APB master on clk; tick is a one-cycle enable from a prescaler.
`timescale 1ns/1ps
module timer_modes_wide_access (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_tick,
    input  wire logic        capture_event,
    input  wire logic        overflow_serviced,
    input  wire logic        compare_a_serviced,
    input  wire logic        compare_b_serviced,
    input  wire logic        capture_serviced,
    output logic             overflow_flag,
    output logic             compare_flag_a,
    output logic             compare_flag_b,
    output logic             capture_flag
);
    timer_pkg::timer_ctrl_s  ctrl_reg;
    timer_pkg::timer_ctrl_s  ctrl_next;
    logic [15:0]             count_reg;
    logic [15:0]             count_next;
    logic [7:0]              cmp_a_reg;
    logic [7:0]              cmp_a_next;
    logic [7:0]              cmp_b_reg;
    logic [7:0]              cmp_b_next;
    logic [7:0]              latch_reg;
    logic [7:0]              latch_next;
    logic                    block_reg;
    logic                    block_next;
    logic                    pend_a_reg;
    logic                    pend_a_next;
    logic                    pend_b_reg;
    logic                    pend_b_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    err_reg;
    logic                    err_next;
    timer_pkg::timer_mode_e  mode;
    timer_pkg::timer_flags_s set_f;
    timer_pkg::timer_flags_s clr_f;
    timer_pkg::timer_flags_s flags;

    logic wr;
    logic rd;
    logic wide;
    logic capt;
    logic adv;
    logic wr_cnt;
    logic match_a;
    logic match_b;
    logic wrap;
    logic [15:0] cmp_word;
    logic [15:0] count_inc;

    assign wr   = psel && penable && pwrite;
    assign rd   = psel && penable && !pwrite;
    assign wide = (mode == timer_pkg::MODE_NORMAL16) || (mode == timer_pkg::MODE_CAPT16);
    assign capt = (mode == timer_pkg::MODE_CAPT8) || (mode == timer_pkg::MODE_CAPT16);
    // Tick only enables; nothing runs on a derived clock
    assign adv  = timer_tick && (ctrl_reg.clock_select_field != timer_pkg::CS_STOP);
    assign wr_cnt = wr && ((paddr == timer_pkg::OFF_CNT_LOW) || (paddr == timer_pkg::OFF_CNT_HIGH && !wide));
    assign cmp_word = {cmp_b_reg, cmp_a_reg};
    assign count_inc = count_reg + timer_pkg::WORD_ONE;

    // Compare units are idle while their register holds a capture value
    assign match_a = wide ? (!capt && count_reg == cmp_word)
                          : (!capt && count_reg[7:0] == cmp_a_reg);
    assign match_b = !wide && count_reg[7:0] == cmp_b_reg;
    assign wrap = wide ? (count_reg == timer_pkg::WORD_MAX)
                       : (count_reg[7:0] == timer_pkg::BYTE_MAX);

    timer_mode_decode u_decode (
        .ctrl (ctrl_reg),
        .mode (mode)
    );

    always_comb begin
        ctrl_next   = ctrl_reg;
        count_next  = count_reg;
        cmp_a_next  = cmp_a_reg;
        cmp_b_next  = cmp_b_reg;
        latch_next  = latch_reg;
        block_next  = block_reg;
        pend_a_next = pend_a_reg;
        pend_b_next = pend_b_reg;
        set_f       = '0;
        clr_f       = '0;

        if (adv) begin
            // Matches seen last tick set flags now, unless a counter write blocked them
            set_f.compare_flag_a = pend_a_reg;
            set_f.compare_flag_b = pend_b_reg;
            pend_a_next = match_a && !block_reg;
            pend_b_next = match_b && !block_reg;
            block_next  = 1'b0;
            // A top of 0xFF in clear-on-match still counts as max to zero
            if (wrap) begin
                set_f.overflow_flag = 1'b1;
            end
            if (mode == timer_pkg::MODE_CLEAR8 && match_a) begin
                count_next = timer_pkg::WORD_ZERO;
            end else if (wrap) begin
                count_next = timer_pkg::WORD_ZERO;
            end else if (wide) begin
                count_next = count_inc;
            end else begin
                count_next = {timer_pkg::BYTE_ZERO, count_inc[7:0]};
            end
        end

        if (capture_event && capt) begin
            cmp_a_next = count_reg[7:0];
            if (wide) begin
                cmp_b_next = count_reg[15:8];
            end
            set_f.capture_flag = 1'b1;
        end

        if (wr) begin
            case (paddr)
                timer_pkg::OFF_CTRL: begin
                    ctrl_next = {pwdata[timer_pkg::CTRL_WIDTH_BIT], pwdata[timer_pkg::CTRL_CAPTURE_BIT],
                         pwdata[timer_pkg::CTRL_CLEAR_BIT],
                         pwdata[timer_pkg::CTRL_CS_LSB +: timer_pkg::CS_WIDTH]};
                end
                timer_pkg::OFF_CNT_HIGH: begin
                    if (wide) begin
                        latch_next = pwdata[7:0];
                    end else begin
                        count_next = {pwdata[7:0], count_reg[7:0]};
                    end
                end
                timer_pkg::OFF_CNT_LOW: begin
                    // CPU write wins over count and clear
                    count_next = wide ? {latch_reg, pwdata[7:0]}
                                      : {count_reg[15:8], pwdata[7:0]};
                end
                timer_pkg::OFF_CMP_A: begin
                    cmp_a_next = pwdata[7:0];
                    if (wide) begin
                        cmp_b_next = latch_reg;
                    end
                end
                timer_pkg::OFF_CMP_B: begin
                    if (wide) begin
                        latch_next = pwdata[7:0];
                    end else begin
                        cmp_b_next = pwdata[7:0];
                    end
                end
                timer_pkg::OFF_FLAGS: begin
                    // Write one to clear
                    clr_f.overflow_flag  = pwdata[timer_pkg::FLAG_OVF_BIT];
                    clr_f.compare_flag_a = pwdata[timer_pkg::FLAG_CMPA_BIT];
                    clr_f.compare_flag_b = pwdata[timer_pkg::FLAG_CMPB_BIT];
                    clr_f.capture_flag   = pwdata[timer_pkg::FLAG_CAP_BIT];
                end
                default: begin
                end
            endcase
        end
        if (wr_cnt) begin
            block_next = 1'b1;
        end

        if (rd && wide) begin
            if (paddr == timer_pkg::OFF_CNT_LOW) begin
                latch_next = count_reg[15:8];
            end else if (paddr == timer_pkg::OFF_CMP_A && capt) begin
                latch_next = cmp_b_reg;
            end
        end

        clr_f.overflow_flag  = clr_f.overflow_flag || overflow_serviced;
        clr_f.compare_flag_a = clr_f.compare_flag_a || compare_a_serviced;
        clr_f.compare_flag_b = clr_f.compare_flag_b || compare_b_serviced;
        clr_f.capture_flag   = clr_f.capture_flag || capture_serviced;
    end

    always_comb begin
        rdata_next = timer_pkg::BUS_ZERO;
        err_next   = 1'b0;
        case (paddr)
            timer_pkg::OFF_CTRL: begin
                rdata_next[timer_pkg::CTRL_WIDTH_BIT]   = ctrl_reg.width_select;
                rdata_next[timer_pkg::CTRL_CAPTURE_BIT] = ctrl_reg.capture_mode_enable;
                rdata_next[timer_pkg::CTRL_CLEAR_BIT]   = ctrl_reg.clear_on_match_select;
                rdata_next[timer_pkg::CTRL_CS_LSB +: timer_pkg::CS_WIDTH] = ctrl_reg.clock_select_field;
            end
            timer_pkg::OFF_CNT_LOW: rdata_next[7:0] = count_reg[7:0];
            timer_pkg::OFF_CNT_HIGH: rdata_next[7:0] = wide ? latch_reg : count_reg[15:8];
            timer_pkg::OFF_CMP_A: rdata_next[7:0] = cmp_a_reg;
            // Compare high byte reads direct, capture high byte through the latch
            timer_pkg::OFF_CMP_B: rdata_next[7:0] = (wide && capt) ? latch_reg : cmp_b_reg;
            timer_pkg::OFF_FLAGS: begin
                rdata_next[timer_pkg::FLAG_OVF_BIT]  = flags.overflow_flag;
                rdata_next[timer_pkg::FLAG_CMPA_BIT] = flags.compare_flag_a;
                rdata_next[timer_pkg::FLAG_CMPB_BIT] = flags.compare_flag_b;
                rdata_next[timer_pkg::FLAG_CAP_BIT]  = flags.capture_flag;
            end
            timer_pkg::OFF_CAPTURE: rdata_next[15:0] = wide ? cmp_word : {timer_pkg::BYTE_ZERO, cmp_a_reg};
            default: err_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg   <= '0;
            count_reg  <= timer_pkg::WORD_ZERO;
            cmp_a_reg  <= timer_pkg::BYTE_ZERO;
            cmp_b_reg  <= timer_pkg::BYTE_ZERO;
            latch_reg  <= timer_pkg::BYTE_ZERO;
            block_reg  <= 1'b0;
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
            rdata_reg  <= timer_pkg::BUS_ZERO;
            err_reg    <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            count_reg  <= count_next;
            cmp_a_reg  <= cmp_a_next;
            cmp_b_reg  <= cmp_b_next;
            latch_reg  <= latch_next;
            block_reg  <= block_next;
            pend_a_reg <= pend_a_next;
            pend_b_reg <= pend_b_next;
            rdata_reg  <= (psel && !penable) ? rdata_next : rdata_reg;
            err_reg    <= (psel && !penable) ? err_next : err_reg;
        end
    end

    timer_flag_bit u_ovf  (.clk(clk), .rst_b(rst_b), .set_evt(set_f.overflow_flag),
                           .clr_evt(clr_f.overflow_flag), .flag(flags.overflow_flag));
    timer_flag_bit u_cmpa (.clk(clk), .rst_b(rst_b), .set_evt(set_f.compare_flag_a),
                           .clr_evt(clr_f.compare_flag_a), .flag(flags.compare_flag_a));
    timer_flag_bit u_cmpb (.clk(clk), .rst_b(rst_b), .set_evt(set_f.compare_flag_b),
                           .clr_evt(clr_f.compare_flag_b), .flag(flags.compare_flag_b));
    timer_flag_bit u_cap  (.clk(clk), .rst_b(rst_b), .set_evt(set_f.capture_flag),
                           .clr_evt(clr_f.capture_flag), .flag(flags.capture_flag));

    // Read data sampled in setup so latch updates do not race the answer
    assign prdata         = rdata_reg;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && err_reg;
    assign overflow_flag  = flags.overflow_flag;
    assign compare_flag_a = flags.compare_flag_a;
    assign compare_flag_b = flags.compare_flag_b;
    assign capture_flag   = flags.capture_flag;
endmodule : timer_modes_wide_access

//--- verif/timer_modes_wide_access_assertions.sv
// Checker for the timer block: flag causes, flag clearing, reset and bus answers.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module timer_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        timer_tick,
    input wire logic        capture_event,
    input wire logic        overflow_serviced,
    input wire logic        capture_serviced,
    input wire logic        overflow_flag,
    input wire logic        compare_flag_a,
    input wire logic        compare_flag_b,
    input wire logic        capture_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic flag_write;
    assign flag_write = psel && penable && pwrite && paddr == timer_pkg::OFF_FLAGS;

    property p_ovf_on_tick;
        $rose(overflow_flag) |-> $past(timer_tick);
    endproperty
    a_ovf_on_tick: assert property (p_ovf_on_tick) else $error("overflow rose without tick");
    property p_ovf_sticky;
        overflow_flag && !overflow_serviced && !flag_write |=> overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped by itself");
    property p_ovf_service;
        overflow_serviced && !timer_tick |=> !overflow_flag;
    endproperty
    a_ovf_service: assert property (p_ovf_service) else $error("overflow not cleared");
    property p_cmpa_on_tick;
        $rose(compare_flag_a) |-> $past(timer_tick);
    endproperty
    a_cmpa_on_tick: assert property (p_cmpa_on_tick) else $error("compare a rose off tick");
    property p_cmpb_on_tick;
        $rose(compare_flag_b) |-> $past(timer_tick);
    endproperty
    a_cmpb_on_tick: assert property (p_cmpb_on_tick) else $error("compare b rose off tick");
    property p_cap_on_event;
        $rose(capture_flag) |-> $past(capture_event);
    endproperty
    a_cap_on_event: assert property (p_cap_on_event) else $error("capture flag without event");
    property p_cap_service;
        capture_serviced && !capture_event |=> !capture_flag;
    endproperty
    a_cap_service: assert property (p_cap_service) else $error("capture flag not cleared");
    property p_reset_flags;
        $rose(rst_b) |-> !overflow_flag && !compare_flag_a && !compare_flag_b && !capture_flag;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flags not clear after reset");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase not ready");
    property p_upper;
        psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
endmodule : timer_checker

bind timer_modes_wide_access timer_checker u_checker (
    .clk               (clk),
    .rst_b             (rst_b),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .prdata            (prdata),
    .pready            (pready),
    .timer_tick        (timer_tick),
    .capture_event     (capture_event),
    .overflow_serviced (overflow_serviced),
    .capture_serviced  (capture_serviced),
    .overflow_flag     (overflow_flag),
    .compare_flag_a    (compare_flag_a),
    .compare_flag_b    (compare_flag_b),
    .capture_flag      (capture_flag)
);

//--- verif/cpu_bus_model.sv
// Behavioural CPU on the APB side: one byte transfer at a time, in program order.
// Assumes a single caller; waits for pready under a bound.
`timescale 1ns/1ps
module cpu_bus_model (
    input wire logic        clk,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    logic [7:0] rdata;
    logic       err;
    logic       hang;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        hang    = 1'b0;
    end

    // Never interleaved, so a two-byte pair cannot be split by another access
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready && n < 16) begin
            n++;
            @(posedge clk);
        end
        hang    = hang || !pready;
        rdata   = prdata[7:0];
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cpu_bus_model

//--- verif/timer_modes_wide_access_test.sv
// Self-checking bench for the timer: modes, flags and the shared high-byte latch.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module timer_modes_wide_access_test;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_tick;
    logic        capture_event;
    logic [3:0]  svc;
    logic        overflow_flag;
    logic        compare_flag_a;
    logic        compare_flag_b;
    logic        capture_flag;
    int          n_errors;
    int          n_compared;
    wire  [7:0]  fl = {4'h0, overflow_flag, compare_flag_a, compare_flag_b, capture_flag};

    always #25 clk = ~clk;

    timer_modes_wide_access DUT (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .capture_event(capture_event),
        .overflow_serviced(svc[3]), .compare_a_serviced(svc[2]),
        .compare_b_serviced(svc[1]), .capture_serviced(svc[0]),
        .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
        .compare_flag_b(compare_flag_b), .capture_flag(capture_flag)
    );

    cpu_bus_model cpu (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(a, 1'b1, d);
    endtask : w

    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        cpu.xfer(a, 1'b0, 8'h00);
        chk(cpu.rdata, exp);
    endtask : r

    task automatic tick(input int n);
        repeat (n) begin
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
            @(posedge clk);
        end
    endtask : tick

    // Bit 4 is the capture event, bits 3:0 the serviced strobes
    task automatic pulse(input logic [4:0] p);
        {capture_event, svc} <= p;
        @(posedge clk);
        {capture_event, svc} <= 5'h00;
        @(posedge clk);
    endtask : pulse

    task automatic s_normal8();
        w(8'h00, 8'h01);
        w(8'h04, 8'hFD);
        tick(2);
        r(8'h04, 8'hFF);
        chk(fl, 8'h00);
        tick(1);
        chk(fl, 8'h08);
        r(8'h04, 8'h00);
        pulse(5'h0F);
        chk(fl, 8'h00);
        w(8'h00, 8'h00);
        w(8'h04, 8'h33);
        tick(2);
        r(8'h04, 8'h33);
    endtask : s_normal8

    task automatic s_block();
        w(8'h0C, 8'h55);
        w(8'h04, 8'h55);
        w(8'h00, 8'h01);
        tick(2);
        chk(fl, 8'h00);
        r(8'h04, 8'h57);
    endtask : s_block

    task automatic s_ctc();
        w(8'h00, 8'h09);
        w(8'h0C, 8'h03);
        w(8'h04, 8'h00);
        tick(4);
        r(8'h04, 8'h00);
        tick(1);
        r(8'h04, 8'h01);
        chk(fl, 8'h04);
        pulse(5'h0F);
        w(8'h04, 8'h10);
        w(8'h0C, 8'h05);
        tick(239);
        r(8'h04, 8'hFF);
        chk(fl & 8'h0C, 8'h00);
        chk(fl & 8'h02, 8'h02);
        tick(1);
        chk(fl & 8'h0C, 8'h08);
    endtask : s_ctc

    task automatic s_wide();
        pulse(5'h0F);
        w(8'h00, 8'h81);
        w(8'h08, 8'hFF);
        w(8'h04, 8'hFE);
        tick(1);
        r(8'h04, 8'hFF);
        r(8'h08, 8'hFF);
        tick(1);
        chk(fl & 8'h08, 8'h08);
        r(8'h04, 8'h00);
        tick(256);
        r(8'h08, 8'h00);
        r(8'h04, 8'h00);
        r(8'h08, 8'h01);
        w(8'h08, 8'h77);
        r(8'h04, 8'h00);
        r(8'h08, 8'h01);
        w(8'h10, 8'hAB);
        w(8'h0C, 8'hCD);
        w(8'h08, 8'h11);
        r(8'h10, 8'hAB);
    endtask : s_wide

    task automatic s_capture();
        w(8'h00, 8'hC0);
        w(8'h08, 8'h12);
        w(8'h04, 8'h34);
        pulse(5'h0F);
        pulse(5'h10);
        chk(fl & 8'h01, 8'h01);
        r(8'h0C, 8'h34);
        r(8'h10, 8'h12);
        w(8'h00, 8'h41);
        w(8'h04, 8'hFF);
        pulse(5'h0F);
        tick(1);
        chk(fl & 8'h08, 8'h08);
        w(8'h04, 8'h9A);
        pulse(5'h10);
        r(8'h0C, 8'h9A);
    endtask : s_capture

    task automatic tally_and_finish();
        if (cpu.hang)
            n_errors++;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clk           = 1'b0;
        rst_b         = 1'b0;
        timer_tick    = 1'b0;
        capture_event = 1'b0;
        svc           = 4'h0;
        n_errors      = 0;
        n_compared    = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        r(8'h00, 8'h00);
        r(8'h04, 8'h00);
        r(8'h0C, 8'h00);
        chk(fl, 8'h00);
        s_normal8();
        s_block();
        s_ctc();
        s_wide();
        s_capture();
        r(8'h14, 8'h09);
        w(8'h14, 8'h01);
        r(8'h14, 8'h08);
        chk(fl, 8'h01);
        r(8'h1C, 8'h00);
        chk({7'h00, cpu.err}, 8'h01);
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : timer_modes_wide_access_test
